// File: rx_baseband_params.svh
`ifndef RX_BASEBAND_PARAMS_SVH
`define RX_BASEBAND_PARAMS_SVH
// ==========================================================
// Register addresses.
`define ADDR_CONTROL 7'h00
`define ADDR_CLK_SEL_LO 7'h06
`define ADDR_CLK_SEL_HI 7'h07
`define ADDR_FILTER_DIV 7'h08
`define ADDR_FEE_CTRL 7'h15
`define ADDR_FEE_RESULT 7'h16
// ==========================================================
// Field positions.
`define CTRL_LOAD_BIT 0
`define CTRL_MODE_LSB 1
`define CTRL_SYNC_BIT 3
`define FILTER_DIV_TOP 2'h3
// ==========================================================
// Reset values.
`define RST_CONTROL 8'h00
`define RST_CLK_SEL_LO 8'h00
`define RST_CLK_SEL_HI 8'h01
`define RST_FILTER_DIV 6'h01
`define RST_FEE_CTRL 4'h0
// ==========================================================
// Mode codes and timing counts.
`define MODE_RECEIVE 2'h2
`define FEE_MODE_OFF 2'h0
`define FEE_MODE_COUNT 2'h3
`define FILTER_PHASES 4
`define OVERSAMPLE 16
`define SAMPLE_PHASE 4'h8
`define BITSYNC_FULL_MASK 7'h7F
`define FEE_MIN_SYMBOLS 7'h08
`endif

// File: rx_baseband_pkg.sv
package rx_baseband_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ADDR = 3'b010,
        ST_DATA = 3'b100
    } prog_state_type;
    typedef logic [7:0] reg_byte_type;
endpackage : rx_baseband_pkg

// File: bit_stream_if.sv
`timescale 1ns/1ps
interface bit_stream_if #(parameter int WIDTH = 1);
    logic [WIDTH-1:0] data;
    logic valid;
    logic ready;
    modport source (output data, output valid, input ready);
    modport sink (input data, input valid, output ready);
endinterface : bit_stream_if

// File: clock_divider.sv
`timescale 1ns/1ps
module clock_divider #(
    parameter int WIDTH = 6
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [WIDTH-1:0] i_divisor,
    output logic o_tick
);
    logic [WIDTH-1:0] cnt_q;

    // ======================================================
    // A divisor of zero behaves as one.
    function automatic logic [WIDTH-1:0] last_count(
        input logic [WIDTH-1:0] div
    );
        if (div == '0) begin
            return '0;
        end
        return div - {{(WIDTH-1){1'b0}}, 1'b1};
    endfunction : last_count

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            cnt_q <= '0;
            o_tick <= 1'b0;
        end else if (cnt_q >= last_count(i_divisor)) begin
            cnt_q <= '0;
            o_tick <= 1'b1;
        end else begin
            cnt_q <= cnt_q + {{(WIDTH-1){1'b0}}, 1'b1};
            o_tick <= 1'b0;
        end
    end

    chk_div_by_one: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_divisor == 1) ##1 (i_divisor == 1) |=> o_tick)
        else $error("Divide by one does not tick every cycle.");
endmodule : clock_divider

// File: bit_fifo.sv
`timescale 1ns/1ps
module bit_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 16
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    bit_stream_if.sink in_s,
    bit_stream_if.source out_s
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    assign in_s.ready = (cnt_q != DEPTH[AW:0]);
    assign out_s.valid = (cnt_q != '0);
    assign out_s.data = mem[rd_q];
    assign push = in_s.valid && in_s.ready;
    assign pop = out_s.valid && out_s.ready;

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wr_q] <= in_s.data;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    chk_fifo_no_overflow: assert property (@(posedge i_clk)
        disable iff (!i_rst_n) cnt_q <= DEPTH[AW:0])
        else $error("FIFO count passed its depth.");
    chk_fifo_count_step: assert property (@(posedge i_clk)
        disable iff (!i_rst_n) push && !pop |=> cnt_q == $past(cnt_q) + 1)
        else $error("FIFO count missed a push.");
endmodule : bit_fifo

// File: rx_baseband_clocks_and_fee.sv
`timescale 1ns/1ps
`include "rx_baseband_params.svh"
// What this block does
// - Crystal divided by six-bit value, then four.
// - Filter clock twenty times cut-off frequency.
// - Demodulator gives up on one, down on zero.
// - Mode 00 off, 11 counts up/down.
// - Measurement spans 8, 16, 32 or 64 symbols.
// - Eight-bit result readable at result address.
// - Load clears the estimator counter to zero.
// - Result is two's complement eight-bit value.
// - Counter wraps, never saturates.
// - Synchronizer on only with sync in receive.
// - Recovered clock driven on data clock pin.
// - Data pin updates on recovered clock rise with sync on, else follows demod bit.
// - Oversample clock is crystal/(K*2^(7-sel)).
// - Reference divider 1..63, select 0..7, shared.
// - Synchronizer adjusts its phase on every data edge except one seen at phase zero.
module rx_baseband_clocks_and_fee (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_prog_clk,
    input wire logic i_prog_en,
    input wire logic i_prog_data,
    output logic o_prog_data,
    output logic o_prog_data_oe,
    input wire logic i_demod_update,
    input wire logic i_demod_bit,
    input wire logic i_data_io_pin,
    output logic o_data_io_pin,
    output logic o_data_io_pin_oe,
    output logic o_recovered_bit_clock,
    output logic o_filter_phase1,
    output logic o_filter_phase2,
    output logic o_tx_data,
    output rx_baseband_pkg::reg_byte_type o_freq_error_count
);
    import rx_baseband_pkg::*;

    // ======================================================
    // Registers and serial programming port.
    reg_byte_type control_q;
    reg_byte_type clk_sel_lo_q;
    reg_byte_type clk_sel_hi_q;
    logic [5:0] channel_filter_divider_q;
    logic [3:0] freq_error_control_q;
    reg_byte_type freq_error_count_q;
    prog_state_type state_q;
    logic sclk_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] addr_sh_q;
    logic [7:0] data_sh_q;
    logic load_q;
    logic sclk_rise;
    logic sclk_fall;
    logic [6:0] addr;
    reg_byte_type rd_byte;

    assign sclk_rise = i_prog_clk && !sclk_q;
    assign sclk_fall = !i_prog_clk && sclk_q;
    assign addr = addr_sh_q[7:1];

    function automatic reg_byte_type reg_read(input logic [6:0] a);
        if (a == `ADDR_CONTROL) begin
            return control_q;
        end else if (a == `ADDR_CLK_SEL_LO) begin
            return clk_sel_lo_q;
        end else if (a == `ADDR_CLK_SEL_HI) begin
            return clk_sel_hi_q;
        end else if (a == `ADDR_FILTER_DIV) begin
            return {`FILTER_DIV_TOP, channel_filter_divider_q};
        end else if (a == `ADDR_FEE_CTRL) begin
            return {4'h0, freq_error_control_q};
        end else if (a == `ADDR_FEE_RESULT) begin
            return freq_error_count_q;
        end
        return 8'h00;
    endfunction : reg_read

    always_comb begin
        rd_byte = reg_read(addr_sh_q[6:0]);
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            sclk_q <= 1'b0;
        end else begin
            sclk_q <= i_prog_clk;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            state_q <= ST_IDLE;
            bit_cnt_q <= 4'h0;
            addr_sh_q <= 8'h00;
            data_sh_q <= 8'h00;
            o_prog_data <= 1'b0;
            o_prog_data_oe <= 1'b0;
        end else if (!i_prog_en) begin
            state_q <= ST_IDLE;
            o_prog_data_oe <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    state_q <= ST_ADDR;
                    bit_cnt_q <= 4'h0;
                end
                ST_ADDR: begin
                    if (sclk_rise) begin
                        addr_sh_q <= {addr_sh_q[6:0], i_prog_data};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                        if (bit_cnt_q == 4'h7) begin
                            state_q <= ST_DATA;
                            bit_cnt_q <= 4'h0;
                            data_sh_q <= rd_byte;
                            o_prog_data <= rd_byte[7];
                            o_prog_data_oe <= i_prog_data;
                        end
                    end
                end
                ST_DATA: begin
                    if (addr_sh_q[0] && sclk_fall) begin
                        data_sh_q <= {data_sh_q[6:0], 1'b0};
                        o_prog_data <= data_sh_q[6];
                    end else if (!addr_sh_q[0] && sclk_rise) begin
                        data_sh_q <= {data_sh_q[6:0], i_prog_data};
                    end
                    if (sclk_rise) begin
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                        if (bit_cnt_q == 4'h7) begin
                            state_q <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    logic wr_commit;
    logic [7:0] wr_data;
    assign wr_commit = (state_q == ST_DATA) && !addr_sh_q[0] && sclk_rise
        && (bit_cnt_q == 4'h7) && i_prog_en;
    assign wr_data = {data_sh_q[6:0], i_prog_data};

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            control_q <= `RST_CONTROL;
            clk_sel_lo_q <= `RST_CLK_SEL_LO;
            clk_sel_hi_q <= `RST_CLK_SEL_HI;
            channel_filter_divider_q <= `RST_FILTER_DIV;
            freq_error_control_q <= `RST_FEE_CTRL;
            load_q <= 1'b0;
        end else begin
            load_q <= wr_commit && (addr == `ADDR_CONTROL)
                && wr_data[`CTRL_LOAD_BIT];
            if (wr_commit) begin
                if (addr == `ADDR_CONTROL) begin
                    control_q <= wr_data;
                end else if (addr == `ADDR_CLK_SEL_LO) begin
                    clk_sel_lo_q <= wr_data;
                end else if (addr == `ADDR_CLK_SEL_HI) begin
                    clk_sel_hi_q <= wr_data;
                end else if (addr == `ADDR_FILTER_DIV) begin
                    channel_filter_divider_q <= wr_data[5:0];
                end else if (addr == `ADDR_FEE_CTRL) begin
                    freq_error_control_q <= wr_data[3:0];
                end
            end
        end
    end

    // ======================================================
    // Channel filter clock phases.
    logic filter_tick;
    logic [1:0] quarter_q;

    clock_divider #(.WIDTH(6)) filter_div (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_divisor(channel_filter_divider_q),
        .o_tick(filter_tick)
    );

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            quarter_q <= 2'h0;
            o_filter_phase1 <= 1'b0;
            o_filter_phase2 <= 1'b0;
        end else if (filter_tick) begin
            quarter_q <= quarter_q + 2'h1;
            o_filter_phase1 <= (quarter_q == 2'h0);
            o_filter_phase2 <= (quarter_q == 2'h2);
        end
    end

    chk_phase_no_overlap: assert property (@(posedge i_clk)
        disable iff (!i_rst_n) o_filter_phase1 |-> !o_filter_phase2)
        else $error("Filter clock phases overlap.");

    // ======================================================
    // Reference divider and oversampling clock.
    logic ref_tick;
    logic [6:0] pre_q;
    logic [6:0] os_mask;
    logic os_tick;
    logic [2:0] bitsync_sel;
    assign bitsync_sel = clk_sel_lo_q[3:1];
    assign os_mask = `BITSYNC_FULL_MASK >> bitsync_sel;
    assign os_tick = ref_tick && ((pre_q & os_mask) == os_mask);

    clock_divider #(.WIDTH(6)) ref_div (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_divisor(clk_sel_hi_q[5:0]),
        .o_tick(ref_tick)
    );

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            pre_q <= 7'h00;
        end else if (ref_tick) begin
            pre_q <= pre_q + 7'h01;
        end
    end

    chk_sel_seven_rate: assert property (@(posedge i_clk)
        disable iff (!i_rst_n) ref_tick && bitsync_sel == 3'h7 |-> os_tick)
        else $error("Select seven does not pass every reference tick.");

    // ======================================================
    // Bit synchronizer.
    logic sync_active;
    logic [3:0] phase_q;
    logic prev_bit_q;
    logic rx_edge;
    logic bit_tick;
    logic clk_out_q;
    logic out_bit_q;
    bit_stream_if #(.WIDTH(1)) fill_s ();
    bit_stream_if #(.WIDTH(1)) drain_s ();

    assign sync_active = control_q[`CTRL_SYNC_BIT] && (control_q[2:1]
        == `MODE_RECEIVE);
    assign rx_edge = os_tick && (i_demod_bit != prev_bit_q);
    assign bit_tick = os_tick && (phase_q == `SAMPLE_PHASE);
    assign fill_s.data = i_demod_bit;
    assign fill_s.valid = bit_tick && sync_active;
    assign drain_s.ready = os_tick && (phase_q == 4'h0) && sync_active;

    bit_fifo #(.WIDTH(1), .DEPTH(`OVERSAMPLE)) rx_fifo (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .in_s(fill_s),
        .out_s(drain_s)
    );

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            phase_q <= 4'h0;
            prev_bit_q <= 1'b0;
        end else if (os_tick) begin
            prev_bit_q <= i_demod_bit;
            if (rx_edge && phase_q != 4'h0 && phase_q < `SAMPLE_PHASE) begin
                phase_q <= phase_q;
            end else if (rx_edge && phase_q >= `SAMPLE_PHASE) begin
                phase_q <= phase_q + 4'h2;
            end else begin
                phase_q <= phase_q + 4'h1;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            clk_out_q <= 1'b0;
            out_bit_q <= 1'b0;
        end else if (drain_s.ready && drain_s.valid) begin
            clk_out_q <= 1'b1;
            out_bit_q <= drain_s.data;
        end else if (os_tick && phase_q == `SAMPLE_PHASE) begin
            clk_out_q <= 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_recovered_bit_clock <= 1'b0;
            o_data_io_pin <= 1'b0;
            o_data_io_pin_oe <= 1'b0;
            o_tx_data <= 1'b0;
        end else begin
            o_recovered_bit_clock <= clk_out_q && sync_active;
            o_data_io_pin <= sync_active ? out_bit_q : i_demod_bit;
            o_data_io_pin_oe <= (control_q[2:1] == `MODE_RECEIVE);
            o_tx_data <= i_data_io_pin;
        end
    end

    chk_clock_gated: assert property (@(posedge i_clk)
        disable iff (!i_rst_n) !sync_active |=> !o_recovered_bit_clock)
        else $error("Recovered clock runs while synchronizer is off.");
    chk_data_on_rise: assert property (@(posedge i_clk)
        disable iff (!i_rst_n) sync_active && $past(sync_active)
        && $past(sync_active, 2) && $changed(o_data_io_pin)
        |-> $rose(o_recovered_bit_clock))
        else $error("Data pin changed away from a rising clock edge.");

    // ======================================================
    // Frequency error estimator.
    logic up_pulse_q;
    logic down_pulse_q;
    logic [6:0] symbols_q;
    logic [6:0] target;
    logic counting;
    assign target = `FEE_MIN_SYMBOLS << freq_error_control_q[3:2];
    assign counting = (freq_error_control_q[1:0] == `FEE_MODE_COUNT)
        && (symbols_q < target);

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            up_pulse_q <= 1'b0;
            down_pulse_q <= 1'b0;
        end else begin
            up_pulse_q <= i_demod_update && i_demod_bit;
            down_pulse_q <= i_demod_update && !i_demod_bit;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            freq_error_count_q <= 8'h00;
            symbols_q <= 7'h00;
        end else if (load_q) begin
            freq_error_count_q <= 8'h00;
            symbols_q <= 7'h00;
        end else if (counting) begin
            freq_error_count_q <= freq_error_count_q
                + {7'h00, up_pulse_q} - {7'h00, down_pulse_q};
            symbols_q <= symbols_q + {6'h00, bit_tick};
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_freq_error_count <= 8'h00;
        end else begin
            o_freq_error_count <= freq_error_count_q;
        end
    end

    chk_load_clears: assert property (@(posedge i_clk)
        disable iff (!i_rst_n) load_q |=> freq_error_count_q == 8'h00)
        else $error("Load did not clear the estimator.");
    chk_off_holds: assert property (@(posedge i_clk)
        disable iff (!i_rst_n) freq_error_control_q[1:0] == `FEE_MODE_OFF
        && !load_q |=> $stable(freq_error_count_q))
        else $error("Estimator moved while off.");
    chk_up_wraps: assert property (@(posedge i_clk)
        disable iff (!i_rst_n) counting && up_pulse_q && !down_pulse_q
        && !load_q |=> freq_error_count_q == $past(freq_error_count_q)
        + 8'h01)
        else $error("Up pulse did not add one.");
    chk_window_ends: assert property (@(posedge i_clk)
        disable iff (!i_rst_n) symbols_q >= target && !load_q
        && $stable(freq_error_control_q) |=> $stable(freq_error_count_q))
        else $error("Estimator counted past its window.");
endmodule : rx_baseband_clocks_and_fee

// File: mcu_data_model.sv
`timescale 1ns/1ps
module mcu_data_model (
    input wire logic i_clk,
    input wire logic i_bit_clk,
    input wire logic i_data,
    input wire logic i_data_oe,
    input wire logic i_drive_en,
    input wire logic i_drive_bit,
    input wire logic i_check_en,
    output logic o_pin,
    output logic [7:0] o_last_bits = 8'h00,
    output int o_violations = 0
);
    logic clk_q = 1'b0;
    logic data_q = 1'b0;
    logic pin_q = 1'b0;
    // ==========================================================
    // Pin level: device, controller, or a released line that toggles.
    assign o_pin = i_data_oe ? i_data : (i_drive_en ? i_drive_bit : ~pin_q);
    // ==========================================================
    // Sampling and edge checks.
    always @(posedge i_clk) begin
        pin_q <= o_pin;
        clk_q <= i_bit_clk;
        data_q <= i_data;
        if (clk_q && !i_bit_clk) begin
            o_last_bits <= {o_last_bits[6:0], i_data};
        end
        if (i_check_en && (i_data !== data_q) && !(i_bit_clk && !clk_q)) begin
            o_violations <= o_violations + 1;
        end
    end
endmodule : mcu_data_model

// File: test_rx_baseband_clocks_and_fee.sv
`timescale 1ns/1ps
`include "rx_baseband_params.svh"
module test_rx_baseband_clocks_and_fee;
    import rx_baseband_pkg::*;
    logic clk = 1'b0;
    logic rst_n, sclk, en, sdo, upd, dbit;
    logic drive_en, drive_bit, check_en, p1_q, rc_q;
    logic sd_out, sd_oe, dp_out, dp_oe, rclk, ph1, ph2, tx, pin;
    logic [7:0] last_bits;
    logic [7:0] r;
    int viol;
    reg_byte_type fee;
    wire logic prog_pin;
    int num_errors;
    int num_checks;
    assign prog_pin = sd_oe ? sd_out : sdo;
    always #25 clk = ~clk;
    always @(posedge clk) begin
        p1_q <= ph1;
        rc_q <= rclk;
    end
    rx_baseband_clocks_and_fee uut (.i_clk(clk), .i_rst_n(rst_n),
        .i_prog_clk(sclk), .i_prog_en(en), .i_prog_data(prog_pin),
        .o_prog_data(sd_out), .o_prog_data_oe(sd_oe),
        .i_demod_update(upd), .i_demod_bit(dbit), .i_data_io_pin(pin),
        .o_data_io_pin(dp_out), .o_data_io_pin_oe(dp_oe),
        .o_recovered_bit_clock(rclk), .o_filter_phase1(ph1),
        .o_filter_phase2(ph2), .o_tx_data(tx), .o_freq_error_count(fee));
    mcu_data_model mcu (.i_clk(clk), .i_bit_clk(rclk), .i_data(dp_out),
        .i_data_oe(dp_oe), .i_drive_en(drive_en), .i_drive_bit(drive_bit),
        .i_check_en(check_en), .o_pin(pin), .o_last_bits(last_bits),
        .o_violations(viol));
    // ==========================================================
    // Shared tasks.
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : print_verdict
    task automatic check(input logic [7:0] got, input logic [7:0] exp,
                         input string what);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: %s got %h want %h", $time, what,
                     got, exp);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task automatic bound(input int t, input int lim);
        if (t >= lim) begin
            num_errors++;
            $display("unexpected at %0t: wait ran out", $time);
            print_verdict();
        end
    endtask : bound
    task automatic frame(input logic [6:0] a, input logic rd,
                         input logic [7:0] wd);
        logic [15:0] bits;
        bits = {a, rd, wd};
        r = 8'h00;
        en <= 1'b1;
        cyc(2);
        for (int i = 0; i < 16; i++) begin
            sdo <= bits[15-i];
            cyc(3);
            sclk <= 1'b1;
            cyc(3);
            if (i >= 7 && i < 15) r = {r[6:0], prog_pin};
            sclk <= 1'b0;
        end
        cyc(3);
        en <= 1'b0;
        cyc(3);
    endtask : frame
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        frame(a, 1'b0, d);
    endtask : wr
    task automatic rdchk(input logic [6:0] a, input logic [7:0] exp,
                         input string what);
        frame(a, 1'b1, 8'h00);
        check(r, exp, what);
    endtask : rdchk
    task automatic pulses(input logic up, input int n);
        for (int i = 0; i < n; i++) begin
            dbit <= up;
            upd <= 1'b1;
            cyc(1);
            upd <= 1'b0;
            cyc(1);
        end
    endtask : pulses
    // ==========================================================
    // Scenarios.
    task automatic t_reset();
        rdchk(`ADDR_CONTROL, 8'h00, "control reset");
        rdchk(`ADDR_CLK_SEL_LO, 8'h00, "select low reset");
        rdchk(`ADDR_CLK_SEL_HI, 8'h01, "select high reset");
        rdchk(`ADDR_FILTER_DIV, 8'hC1, "divider reset");
        rdchk(`ADDR_FEE_CTRL, 8'h00, "fee control reset");
        rdchk(`ADDR_FEE_RESULT, 8'h00, "fee reset");
        wr(7'h30, 8'h5A);
        rdchk(7'h30, 8'h00, "unmapped");
        $display("test reset done");
    endtask : t_reset
    task automatic t_filter(input logic [5:0] k);
        int t;
        int n;
        int ov;
        wr(`ADDR_FILTER_DIV, {2'h0, k});
        rdchk(`ADDR_FILTER_DIV, {2'h3, k}, "divider");
        ov = 0;
        for (t = 0; t < 600 && !(ph1 && !p1_q); t++) cyc(1);
        bound(t, 600);
        n = 0;
        do begin
            cyc(1);
            n++;
            if (ph1 && ph2) ov++;
        end while (n < 600 && !(ph1 && !p1_q));
        bound(n, 600);
        check(n[7:0], 8'(4 * k), "filter period");
        check(ov[7:0], 8'h00, "phase overlap");
        $display("test filter %0d done", k);
    endtask : t_filter
    task automatic t_fee();
        wr(`ADDR_CLK_SEL_LO, 8'h00);
        wr(`ADDR_FEE_CTRL, 8'h03);
        wr(`ADDR_CONTROL, 8'h01);
        pulses(1'b1, 5);
        pulses(1'b0, 2);
        rdchk(`ADDR_FEE_RESULT, 8'h03, "fee up down");
        check(fee, 8'h03, "fee port");
        wr(`ADDR_CONTROL, 8'h01);
        rdchk(`ADDR_FEE_RESULT, 8'h00, "fee after load");
        pulses(1'b0, 1);
        rdchk(`ADDR_FEE_RESULT, 8'hFF, "fee minus one");
        pulses(1'b1, 129);
        rdchk(`ADDR_FEE_RESULT, 8'h80, "fee wrap");
        wr(`ADDR_FEE_RESULT, 8'h55);
        rdchk(`ADDR_FEE_RESULT, 8'h80, "fee read only");
        for (int m = 0; m < 3; m++) begin
            wr(`ADDR_FEE_CTRL, {6'h00, m[1:0]});
            wr(`ADDR_CONTROL, 8'h01);
            pulses(1'b1, 4);
            rdchk(`ADDR_FEE_RESULT, 8'h00, "fee idle mode");
        end
        wr(`ADDR_CLK_SEL_LO, 8'h08);
        for (int c = 0; c < 4; c++) begin
            wr(`ADDR_FEE_CTRL, {4'h0, c[1:0], 2'h3});
            wr(`ADDR_CONTROL, 8'h01);
            cyc((8 << c) * 128 - 300);
            pulses(1'b1, 1);
            cyc(600);
            pulses(1'b1, 1);
            rdchk(`ADDR_FEE_RESULT, 8'h01, "fee window");
        end
        $display("test fee done");
    endtask : t_fee
    task automatic t_plain();
        int rises;
        wr(`ADDR_CONTROL, 8'h05);
        check({7'h00, dp_oe}, 8'h01, "rx pin drive");
        rises = 0;
        for (int b = 0; b < 6; b++) begin
            dbit <= b[0];
            cyc(3);
            if (rclk) rises++;
            check({7'h00, dp_out}, {7'h00, b[0]}, "plain data");
        end
        check(rises[7:0], 8'h00, "clock idle");
        $display("test plain done");
    endtask : t_plain
    task automatic t_sync();
        logic [7:0] pat;
        int rises;
        logic ok;
        pat = 8'hB2;
        rises = 0;
        ok = 1'b0;
        wr(`ADDR_CLK_SEL_LO, 8'h0E);
        wr(`ADDR_CONTROL, 8'h0D);
        for (int b = 0; b < 64; b++) begin
            dbit <= pat[7 - (b % 8)];
            if (b == 24) check_en <= 1'b1;
            for (int c = 0; c < 16; c++) begin
                cyc(1);
                if (b >= 24 && rclk && !rc_q) rises++;
            end
        end
        check_en <= 1'b0;
        check({7'h00, rises >= 39 && rises <= 41}, 8'h01, "clock rate");
        for (int k = 0; k < 8; k++) begin
            if (last_bits === ((pat << k) | (pat >> (8 - k)))) ok = 1'b1;
        end
        check({7'h00, ok}, 8'h01, "locked data");
        check(viol[7:0], 8'h00, "data edge");
        $display("test sync done");
    endtask : t_sync
    task automatic t_tx();
        wr(`ADDR_CONTROL, 8'h07);
        check({7'h00, dp_oe}, 8'h00, "tx pin released");
        drive_en <= 1'b1;
        for (int v = 0; v < 2; v++) begin
            drive_bit <= v[0];
            cyc(3);
            check({7'h00, tx}, {7'h00, v[0]}, "tx data");
        end
        drive_en <= 1'b0;
        $display("test tx done");
    endtask : t_tx
    // ==========================================================
    // Main sequence.
    initial begin
        rst_n = 1'b0;
        sclk = 1'b0;
        en = 1'b0;
        sdo = 1'b0;
        upd = 1'b0;
        dbit = 1'b0;
        drive_en = 1'b0;
        drive_bit = 1'b0;
        check_en = 1'b0;
        num_errors = 0;
        num_checks = 0;
        cyc(8);
        rst_n <= 1'b1;
        cyc(1);
        t_reset();
        t_filter(6'h01);
        t_filter(6'h05);
        t_filter(6'h3F);
        t_fee();
        t_plain();
        t_sync();
        t_tx();
        print_verdict();
    end
endmodule : test_rx_baseband_clocks_and_fee
